// ===== common/bus_ctrl_pkg.sv
package bus_ctrl_pkg;

  localparam int NUM_MASTERS = 3;
  localparam int MST_ETH     = 0;
  localparam int MST_PER     = 1;
  localparam int MST_CPU     = 2;

  // register byte offsets on the apb side
  localparam logic [7:0] OFF_REMAP_CONTROL        = 8'h00;
  localparam logic [7:0] OFF_ABORT_STATUS         = 8'h04;
  localparam logic [7:0] OFF_ABORT_ADDRESS_STATUS = 8'h08;

  // field positions
  localparam int POS_REMAP_TOGGLE = 0;
  localparam int POS_UNDEF        = 0;
  localparam int POS_MISALIGN     = 1;
  localparam int POS_SIZE         = 8;
  localparam int POS_KIND         = 10;
  localparam int POS_LAST         = 16;
  localparam int POS_SAVED        = 24;

  // address map
  localparam logic [3:0] REGION_INTMEM = 4'h0;
  localparam logic [3:0] REGION_PERIPH = 4'hf;
  localparam logic [7:0] SLOT_BOOT     = 8'h00;
  localparam logic [7:0] SLOT_FLASH    = 8'h01;
  localparam logic [7:0] SLOT_SRAM     = 8'h02;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } xfer_size_e;

  typedef enum logic [1:0] {
    KIND_READ  = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_FETCH = 2'h2
  } xfer_kind_e;

  typedef enum logic [1:0] {
    TGT_NONE   = 2'h0,
    TGT_FLASH  = 2'h1,
    TGT_SRAM   = 2'h2,
    TGT_PERIPH = 2'h3
  } target_e;

  // one master's request
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    xfer_size_e  size;
    xfer_kind_e  kind;
    logic [31:0] wdata;
  } bus_req_s;

  // request as driven toward a slave
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    xfer_size_e  size;
    logic        write;
    logic [31:0] wdata;
  } slave_req_s;

endpackage : bus_ctrl_pkg

// ===== tb/bus_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_monitor #(
  parameter int FLASH_ADDR_BITS = 19,
  parameter int SRAM_ADDR_BITS  = 17
) (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire bus_ctrl_pkg::bus_req_s   ethReq,
  input wire bus_ctrl_pkg::bus_req_s   perReq,
  input wire logic [2:0]               grant,
  input wire logic                     xferDone,
  input wire logic                     abortAll,
  input wire bus_ctrl_pkg::slave_req_s flashReq,
  input wire bus_ctrl_pkg::slave_req_s sramReq,
  input wire bus_ctrl_pkg::slave_req_s periphReq,
  input wire logic                     flashReady,
  input wire logic                     sramReady,
  input wire logic                     remapActive,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [31:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic                     pready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // the write commits on the edge where pready is seen high
  sequence apbDone;
    psel && penable && pready;
  endsequence
  sequence remapHit;
    apbDone ##0 (pwrite && paddr == 32'h0);
  endsequence
  ////////////////////////////////////////
  grant_priority_a: assert property ($rose(|grant) |-> grant ==
    ($past(ethReq.req) ? 3'h1 : $past(perReq.req) ? 3'h2 : 3'h4)) else $error("grant order");
  grant_hold_a: assert property ($past(|grant) && grant != $past(grant)
    |-> $past(xferDone)) else $error("grant changed mid transfer");
  abort_done_a: assert property (abortAll |-> xferDone) else $error("abort without done");
  abort_cancel_a: assert property (abortAll |->
    !(flashReq.valid || sramReq.valid || periphReq.valid)) else $error("aborted access issued");
  sram_alias_a: assert property (sramReq.valid |->
    (sramReq.addr >> SRAM_ADDR_BITS) == 0) else $error("sram offset not masked");
  flash_alias_a: assert property (flashReq.valid |->
    (flashReq.addr >> FLASH_ADDR_BITS) == 0) else $error("flash offset not masked");
  ready_done_a: assert property (
    (sramReq.valid && sramReady) || (flashReq.valid && flashReady)
    |=> xferDone) else $error("done not after ready");
  flash_hold_a: assert property (flashReq.valid && !flashReady |=> flashReq.valid)
    else $error("flash request dropped early");
  remap_toggle_a: assert property (remapHit |=>
    remapActive == ($past(remapActive) ^ $past(pwdata[0]))) else $error("remap toggle wrong");
  remap_reset_a: assert property ($fell(srst) |-> !remapActive)
    else $error("remap after reset");
endmodule // bus_ctrl_monitor

bind system_bus_arbiter_decoder bus_ctrl_monitor #(
  .FLASH_ADDR_BITS(FLASH_ADDR_BITS), .SRAM_ADDR_BITS(SRAM_ADDR_BITS)
) mon (
  .clk(clk), .srst(srst), .ethReq(ethReq), .perReq(perReq), .grant(grant),
  .xferDone(xferDone), .abortAll(abortAll), .flashReq(flashReq), .sramReq(sramReq),
  .periphReq(periphReq), .flashReady(flashReady), .sramReady(sramReady),
  .remapActive(remapActive), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready)
);
`default_nettype wire

// ===== tb/mem_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_slave_model #(
  parameter int          WAIT = 0,
  parameter logic [31:0] KEY  = 32'h0
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire bus_ctrl_pkg::slave_req_s req,
  output logic                          ready,
  output logic [31:0]                   rdata
);
  int   cnt;
  logic hold;
  logic junk;
  // data lines toggle outside the answer cycle so a stale word never matches
  assign rdata = ready ? (req.addr ^ KEY) : {32{junk}};
  always_ff @(posedge clk) begin
    junk  <= srst ? 1'b0 : ~junk;
    ready <= 1'b0;
    if (srst || !req.valid) begin
      cnt  <= 0;
      hold <= 1'b0;
    end else if (!hold) begin
      if (cnt == WAIT) begin
        ready <= 1'b1;
        hold  <= 1'b1;
      end else cnt <= cnt + 1;
    end
  end
endmodule // mem_slave_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int          FB   = 16;
  localparam int          SB   = 12;
  localparam logic [31:0] KFL  = 32'h1100_0000;
  localparam logic [31:0] KSR  = 32'h2200_0000;
  localparam logic [31:0] AST  = {24'h0, bus_ctrl_pkg::OFF_ABORT_STATUS};
  localparam logic [31:0] AAD  = {24'h0, bus_ctrl_pkg::OFF_ABORT_ADDRESS_STATUS};
  logic                     clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic                     xferDone, abortAll, remapActive, pready, pslverr, fRdy, sRdy, pRdy;
  logic [2:0]               grant;
  logic [31:0]              rdata, prdata, fRd, sRd, pRd, paddr = 0, pwdata = 0;
  bus_ctrl_pkg::bus_req_s   m [3];
  bus_ctrl_pkg::slave_req_s fReq, sReq, pReq;
  int                       badCount = 0, testsRun = 0, cyc = 0;
  always #5 clk = ~clk;
  system_bus_arbiter_decoder #(.FLASH_ADDR_BITS(FB), .SRAM_ADDR_BITS(SB)) uut (
    .clk(clk), .srst(srst), .ethReq(m[0]), .perReq(m[1]), .cpuReq(m[2]), .grant(grant),
    .xferDone(xferDone), .abortAll(abortAll), .rdata(rdata), .flashReq(fReq),
    .sramReq(sReq), .periphReq(pReq), .flashReady(fRdy), .flashRdata(fRd),
    .sramReady(sRdy), .sramRdata(sRd), .periphReady(pRdy), .periphRdata(pRd),
    .remapActive(remapActive), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // flash slow, sram prompt, peripherals in between
  mem_slave_model #(.WAIT(2), .KEY(KFL)) fl (.clk(clk), .srst(srst), .req(fReq), .ready(fRdy), .rdata(fRd));
  mem_slave_model #(.WAIT(0), .KEY(KSR)) sr (.clk(clk), .srst(srst), .req(sReq), .ready(sRdy), .rdata(sRd));
  mem_slave_model #(.WAIT(1), .KEY(0)) pe (.clk(clk), .srst(srst), .req(pReq), .ready(pRdy), .rdata(pRd));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic raise(input int w, input logic [31:0] a, input logic [1:0] sz, k);
    m[w] <= '{1'b1, a, bus_ctrl_pkg::xfer_size_e'(sz), bus_ctrl_pkg::xfer_kind_e'(k), ~a};
  endtask
  task automatic waitDone(output logic [31:0] d, output logic ab, output logic [2:0] g);
    g = 0;
    do begin
      @(posedge clk);
      if (g == 0) g = grant;
    end while (xferDone !== 1'b1);
    d = rdata;
    ab = abortAll;
  endtask
  task automatic mx(input int w, input logic [31:0] a, input logic [1:0] sz, k,
                    output logic [31:0] d, output logic ab);
    logic [2:0] g;
    @(posedge clk);
    raise(w, a, sz, k);
    waitDone(d, ab, g);
    // every master drops its request on done, abort or not
    m[w].req <= 0;
  endtask
  ////////////////////////////////////////
  task automatic regs;
    logic [31:0] d;
    logic        e;
    apb(0, AST, 0, d, e); chk("status", d, 0);
    apb(0, AAD, 0, d, e); chk("abortAddr", d, 0);
    apb(0, 32'h1c, 0, d, e); chk("unmapped", {31'h0, e}, 1);
    chk("remapInit", {31'h0, remapActive}, 0);
  endtask
  task automatic maps;
    logic [31:0] d;
    logic        ab, e;
    for (int p = 0; p < 3; p++) begin
      mx(2, 32'h0000_0104, 2, 0, d, ab); chk("boot", d, 32'h104 ^ (p == 1 ? KSR : KFL));
      mx(2, 32'h0010_0104 | (32'h1 << FB), 2, 0, d, ab); chk("flash", d, 32'h104 ^ KFL);
      mx(2, 32'h0020_0104 | (32'h1 << SB), 2, 0, d, ab); chk("sram", d, 32'h104 ^ KSR);
      // bit0 clear must leave the mapping alone
      apb(1, 0, p == 2 ? 32'h2 : 32'h1, d, e);
      // the toggle lands on the completing edge, so look one edge later
      @(posedge clk);
      chk("remap", {31'h0, remapActive}, p == 0);
    end
    mx(1, 32'hf000_0010, 2, 1, d, ab); chk("periph", {31'h0, ab}, 0);
  endtask
  task automatic prio;
    logic [31:0] d;
    logic        ab;
    logic [2:0]  g;
    int          who [3] = '{2, 0, 1};
    @(posedge clk);
    raise(2, 32'h0010_0008, 2, 0);
    repeat (2) @(posedge clk);
    raise(1, 32'h0020_0010, 2, 0);
    raise(0, 32'h0020_0020, 2, 0);
    for (int i = 0; i < 3; i++) begin
      waitDone(d, ab, g);
      chk("owner", {29'h0, g}, 32'h1 << who[i]);
      m[who[i]].req <= 0;
    end
  endtask
  task automatic ab1(input int w, input logic [31:0] a, input logic [1:0] sz, k,
                     input logic und, mis, sv);
    logic [31:0] d, st;
    logic        ab, e;
    mx(w, a, sz, k, d, ab);
    chk("abortAll", {31'h0, ab}, {31'h0, und | mis});
    if (und | mis) begin
      st = {31'h0, und} | {30'h0, mis, 1'b0} | ({30'h0, sz} << bus_ctrl_pkg::POS_SIZE)
         | ({30'h0, k} << bus_ctrl_pkg::POS_KIND) | (32'h1 << (bus_ctrl_pkg::POS_LAST + w))
         | ({31'h0, sv} << (bus_ctrl_pkg::POS_SAVED + w));
      apb(0, AAD, 0, d, e); chk("abortAddr", d, a);
      apb(0, AST, 0, d, e); chk("status", d, st);
    end
  endtask
  task automatic aborts;
    logic [31:0] d;
    logic        ab, e;
    ab1(0, 32'h0020_0002, 2, 0, 0, 1, 0);
    ab1(1, 32'h0020_0001, 1, 1, 0, 1, 0);
    ab1(2, 32'h3000_0000, 0, 0, 1, 0, 0);
    ab1(0, 32'h0050_0000, 2, 1, 1, 0, 0);
    ab1(2, 32'h0010_0002, 2, 2, 0, 0, 0);
    ab1(2, 32'h0020_0006, 1, 0, 0, 0, 0);
    mx(2, 32'h0020_0003, 2, 0, d, ab);
    ab1(2, 32'h7000_0004, 2, 1, 1, 0, 1);
    apb(0, AST, 0, d, e); chk("savedClear", {29'h0, d[26:24]}, 0);
  endtask
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      badCount++;
      giveVerdict();
    end
  end
  initial begin
    for (int i = 0; i < 3; i++) m[i] = '0;
    repeat (6) @(posedge clk);
    srst <= 0;
    regs();
    maps();
    prio();
    aborts();
    giveVerdict();
  end
endmodule // tb
`default_nettype wire

// ===== verilog/system_bus_arbiter_decoder.sv
// How it works
// - fixed priority: ethernet, peripheral dma, processor
// - little-endian only, byte lanes fixed
// - top four address bits pick region
// - memory and peripheral regions, others abort
// - eight more bits pick 1-Mbyte slot
// - small memories alias across their slot
// - unassigned memory slot gives abort
// - slot zero flash, sram after remap
// - boot memory also at native base
// - writing one toggles remap state
// - abort driven to every master
// - capture full abort address
// - record abort transfer size
// - record read, write or fetch
// - exactly one cause flag set
// - flag master of last abort
// - sticky saved flags, cleared by read
// - data abort stores data address
// - word/half alignment checked on bits
// - misaligned access cancelled, aborted
// - processor fetches skip alignment check
`timescale 1ns/1ps
`default_nettype none

module system_bus_arbiter_decoder #(
  parameter int FLASH_ADDR_BITS = 19,
  parameter int SRAM_ADDR_BITS  = 17
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire bus_ctrl_pkg::bus_req_s    ethReq,
  input  wire bus_ctrl_pkg::bus_req_s    perReq,
  input  wire bus_ctrl_pkg::bus_req_s    cpuReq,
  output logic [2:0]                     grant,
  output logic                           xferDone,
  output logic                           abortAll,
  output logic [31:0]                    rdata,
  output bus_ctrl_pkg::slave_req_s       flashReq,
  output bus_ctrl_pkg::slave_req_s       sramReq,
  output bus_ctrl_pkg::slave_req_s       periphReq,
  input  wire logic                      flashReady,
  input  wire logic [31:0]               flashRdata,
  input  wire logic                      sramReady,
  input  wire logic [31:0]               sramRdata,
  input  wire logic                      periphReady,
  input  wire logic [31:0]               periphRdata,
  output logic                           remapActive,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUSY  = 3'b010,
    ST_DONE  = 3'b100
  } state_e;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic misaligned(input bus_ctrl_pkg::bus_req_s r);
    logic bad;
    bad = 1'b0;
    if (r.size == bus_ctrl_pkg::SIZE_WORD)
      bad = r.addr[1] | r.addr[0];
    else if (r.size == bus_ctrl_pkg::SIZE_HALF)
      bad = r.addr[0];
    if (r.kind == bus_ctrl_pkg::KIND_FETCH)
      bad = 1'b0;
    return bad;
  endfunction

  function automatic bus_ctrl_pkg::target_e decode(input logic [31:0] a, input logic remap);
    bus_ctrl_pkg::target_e t;
    t = bus_ctrl_pkg::TGT_NONE;
    if (a[31:28] == bus_ctrl_pkg::REGION_PERIPH)
      t = bus_ctrl_pkg::TGT_PERIPH;
    else if (a[31:28] == bus_ctrl_pkg::REGION_INTMEM) begin
      case (a[27:20])
        bus_ctrl_pkg::SLOT_BOOT:
          t = remap ? bus_ctrl_pkg::TGT_SRAM : bus_ctrl_pkg::TGT_FLASH;
        bus_ctrl_pkg::SLOT_FLASH: t = bus_ctrl_pkg::TGT_FLASH;
        bus_ctrl_pkg::SLOT_SRAM:  t = bus_ctrl_pkg::TGT_SRAM;
        default:                  t = bus_ctrl_pkg::TGT_NONE;
      endcase
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  state_e state;
  state_e next_state;
  logic [2:0] owner;
  bus_ctrl_pkg::bus_req_s cur;
  bus_ctrl_pkg::target_e  curTgt;
  logic curMis;

  // ethernet first, peripheral dma second, processor last
  wire logic [2:0] pick = ethReq.req ? 3'b001 :
                          perReq.req ? 3'b010 :
                          cpuReq.req ? 3'b100 : 3'b000;
  wire bus_ctrl_pkg::bus_req_s pickReq = pick[bus_ctrl_pkg::MST_ETH] ? ethReq :
                                         pick[bus_ctrl_pkg::MST_PER] ? perReq : cpuReq;
  wire bus_ctrl_pkg::bus_req_s ownReq  = owner[bus_ctrl_pkg::MST_ETH] ? ethReq :
                                         owner[bus_ctrl_pkg::MST_PER] ? perReq : cpuReq;

  wire logic pickMis = misaligned(pickReq);
  wire bus_ctrl_pkg::target_e pickTgt = decode(pickReq.addr, remapActive);
  wire logic pickAbort = pickMis | (pickTgt == bus_ctrl_pkg::TGT_NONE);

  wire logic tgtReady = (curTgt == bus_ctrl_pkg::TGT_FLASH)  ? flashReady :
                        (curTgt == bus_ctrl_pkg::TGT_SRAM)   ? sramReady  :
                        (curTgt == bus_ctrl_pkg::TGT_PERIPH) ? periphReady : 1'b0;
  wire logic [31:0] tgtRdata = (curTgt == bus_ctrl_pkg::TGT_FLASH) ? flashRdata :
                               (curTgt == bus_ctrl_pkg::TGT_SRAM)  ? sramRdata  : periphRdata;

  // small memories alias across the slot: upper offset bits are dropped
  wire logic [31:0] flashMask = (32'h1 << FLASH_ADDR_BITS) - 32'h1;
  wire logic [31:0] sramMask  = (32'h1 << SRAM_ADDR_BITS) - 32'h1;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (pick != 3'b000) next_state = pickAbort ? ST_DONE : ST_BUSY;
      ST_BUSY: if (tgtReady) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state  <= ST_IDLE;
      owner  <= 3'b000;
      cur    <= '0;
      curTgt <= bus_ctrl_pkg::TGT_NONE;
      curMis <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && pick != 3'b000) begin
        owner  <= pick;
        cur    <= pickReq;
        curTgt <= pickTgt;
        curMis <= pickMis;
      end else if (state == ST_DONE) begin
        owner  <= 3'b000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave side: an aborted access never reaches a slave

  wire logic issue = (state == ST_IDLE) && (pick != 3'b000) && !pickAbort;
  wire logic busyHold = (state == ST_BUSY) && !tgtReady;

  function automatic bus_ctrl_pkg::slave_req_s mk(input bus_ctrl_pkg::bus_req_s r,
                                                  input logic [31:0] mask);
    bus_ctrl_pkg::slave_req_s s;
    s.valid = 1'b1;
    s.addr  = r.addr & mask;
    s.size  = r.size;
    s.write = (r.kind == bus_ctrl_pkg::KIND_WRITE);
    s.wdata = r.wdata;
    return s;
  endfunction

  wire logic issueFlash = issue && (pickTgt == bus_ctrl_pkg::TGT_FLASH);
  wire logic issueSram  = issue && (pickTgt == bus_ctrl_pkg::TGT_SRAM);
  wire logic issuePer   = issue && (pickTgt == bus_ctrl_pkg::TGT_PERIPH);
  wire logic holdFlash  = busyHold && (curTgt == bus_ctrl_pkg::TGT_FLASH);
  wire logic holdSram   = busyHold && (curTgt == bus_ctrl_pkg::TGT_SRAM);
  wire logic holdPer    = busyHold && (curTgt == bus_ctrl_pkg::TGT_PERIPH);

  always_ff @(posedge clk) begin
    if (srst) begin
      flashReq  <= '0;
      sramReq   <= '0;
      periphReq <= '0;
    end else begin
      flashReq  <= issueFlash ? mk(pickReq, flashMask) : holdFlash ? flashReq  : '0;
      sramReq   <= issueSram  ? mk(pickReq, sramMask)  : holdSram  ? sramReq   : '0;
      periphReq <= issuePer   ? mk(pickReq, 32'hffffffff) : holdPer ? periphReq : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer to masters

  wire logic abortNow = (state == ST_IDLE) && (pick != 3'b000) && pickAbort;

  always_ff @(posedge clk) begin
    if (srst) begin
      grant    <= 3'b000;
      xferDone <= 1'b0;
      abortAll <= 1'b0;
      rdata    <= 32'h0;
    end else begin
      grant    <= (next_state == ST_IDLE) ? 3'b000 :
                  (state == ST_IDLE) ? pick : owner;
      xferDone <= abortNow || ((state == ST_BUSY) && tgtReady);
      // one line to all masters; the dma masters ignore it
      abortAll <= abortNow;
      if ((state == ST_BUSY) && tgtReady && cur.kind != bus_ctrl_pkg::KIND_WRITE)
        rdata <= tgtRdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb registers

  logic [31:0] abortAddr;
  logic [1:0]  abortSize;
  logic [1:0]  abortKind;
  logic        undefFlag;
  logic        misFlag;
  logic [2:0]  lastMaster;
  logic [2:0]  savedMaster;
  logic [2:0]  pendMaster;

  // reads latch on the first access edge, writes land once pready is seen high
  wire logic apbAccess = psel && penable && !pready;
  wire logic apbWrite  = psel && penable && pready && pwrite;
  wire logic apbRead   = apbAccess && !pwrite;
  wire logic hitRemap  = (paddr[7:0] == bus_ctrl_pkg::OFF_REMAP_CONTROL);
  wire logic hitStatus = (paddr[7:0] == bus_ctrl_pkg::OFF_ABORT_STATUS);
  wire logic hitAddr   = (paddr[7:0] == bus_ctrl_pkg::OFF_ABORT_ADDRESS_STATUS);
  wire logic hitAny    = (paddr[31:8] == 24'h0) && (hitRemap || hitStatus || hitAddr);
  wire logic statusRead = apbRead && hitAny && hitStatus;
  wire logic toggleRemap = apbWrite && hitAny && hitRemap && pwdata[bus_ctrl_pkg::POS_REMAP_TOGGLE];

  wire logic [31:0] statusWord =
      (32'(savedMaster) << bus_ctrl_pkg::POS_SAVED) |
      (32'(lastMaster)  << bus_ctrl_pkg::POS_LAST)  |
      (32'(abortKind)   << bus_ctrl_pkg::POS_KIND)  |
      (32'(abortSize)   << bus_ctrl_pkg::POS_SIZE)  |
      (32'(misFlag)     << bus_ctrl_pkg::POS_MISALIGN) |
      (32'(undefFlag)   << bus_ctrl_pkg::POS_UNDEF);

  // write-only and unmapped words read zero; unmapped ones also flag an error
  wire logic [31:0] readWord = (hitAny && hitStatus) ? statusWord :
                               (hitAny && hitAddr)   ? abortAddr  : 32'h0;

  // an abort that lands on a status read still leaves its saved bit set
  wire logic [2:0] savedKeep = statusRead ? 3'b000 : savedMaster;
  // a new abort pushes every unread earlier abort out of the last-source bits
  wire logic [2:0] savedSet  = abortNow ? pendMaster : 3'b000;
  wire logic [2:0] pendKeep  = statusRead ? 3'b000 : pendMaster;
  wire logic [2:0] pendSet   = abortNow ? pick : 3'b000;

  always_ff @(posedge clk) begin
    if (srst) begin
      remapActive <= 1'b0;
      abortAddr   <= 32'h0;
      abortSize   <= 2'h0;
      abortKind   <= 2'h0;
      undefFlag   <= 1'b0;
      misFlag     <= 1'b0;
      lastMaster  <= 3'b000;
      savedMaster <= 3'b000;
      pendMaster  <= 3'b000;
      prdata      <= 32'h0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      if (toggleRemap)
        remapActive <= ~remapActive;
      if (abortNow) begin
        abortAddr  <= pickReq.addr;
        abortSize  <= pickReq.size;
        abortKind  <= pickReq.kind;
        undefFlag  <= ~pickMis;
        misFlag    <= pickMis;
        lastMaster <= pick;
      end
      savedMaster <= savedKeep | savedSet;
      pendMaster  <= pendKeep | pendSet;
      pready  <= apbAccess && !pready;
      pslverr <= apbAccess && !pready && !hitAny;
      prdata  <= (apbRead && !pready) ? readWord : 32'h0;
    end
  end

endmodule // system_bus_arbiter_decoder

`default_nettype wire
